//--- inc/irq_pkg.sv
// Shared constants and types for the nested vectored interrupt unit
package irq_pkg;
    // Source counts
    localparam int NUM_PERIPH = 64;
    localparam int NUM_SYS = 16;
    localparam int NUM_EXC = NUM_SYS + NUM_PERIPH;
    localparam int IDX_W = 7;
    localparam int PRIO_W = 3;
    localparam int NUM_LEVELS = 8;
    localparam int KEY_W = 4;
    localparam int TICK_W = 24;

    // Table index = exception number + 16; vector byte address = 4 * index
    localparam logic [31:0] VEC_BASE = 32'h0000_0000;
    localparam logic [31:0] VEC_STRIDE = 32'h0000_0004;
    localparam logic [31:0] VEC_PERIPH_BASE = 32'h0000_0040;
    localparam logic [IDX_W-1:0] IDX_STACK = 7'h00;
    localparam logic [IDX_W-1:0] IDX_RESET = 7'h01;
    localparam logic [IDX_W-1:0] IDX_NMI = 7'h02;
    localparam logic [IDX_W-1:0] IDX_HARD = 7'h03;
    localparam logic [IDX_W-1:0] IDX_MEM = 7'h04;
    localparam logic [IDX_W-1:0] IDX_BUS = 7'h05;
    localparam logic [IDX_W-1:0] IDX_USAGE = 7'h06;
    localparam logic [IDX_W-1:0] IDX_SVC = 7'h0B;
    localparam logic [IDX_W-1:0] IDX_DEBUG = 7'h0C;
    localparam logic [IDX_W-1:0] IDX_PENDSV = 7'h0E;
    localparam logic [IDX_W-1:0] IDX_TICK = 7'h0F;
    localparam logic [IDX_W-1:0] IDX_PERIPH0 = 7'h10;

    // System entries that can be pended (stack, reset, reserved excluded)
    localparam logic [NUM_SYS-1:0] SYS_PENDABLE = 16'hD87C;
    // Peripheral lines wired to a source; the other 25 never assert
    localparam logic [NUM_PERIPH-1:0] PERIPH_WIRED =
        64'h0003_FBF3_3FFF_61EF;

    // Fixed keys for the three top exceptions; programmable ones add 3
    localparam logic [KEY_W-1:0] KEY_RESET = 4'h0;
    localparam logic [KEY_W-1:0] KEY_NMI = 4'h1;
    localparam logic [KEY_W-1:0] KEY_HARD = 4'h2;
    localparam logic [KEY_W-1:0] KEY_PROG_BASE = 4'h3;
    localparam logic [KEY_W-1:0] KEY_IDLE = 4'hF;

    typedef logic [NUM_EXC-1:0][KEY_W-1:0] key_arr_t;

    // Programmable priorities of the configurable system exceptions
    typedef struct packed {
        logic [PRIO_W-1:0] mem;
        logic [PRIO_W-1:0] bus;
        logic [PRIO_W-1:0] usage;
        logic [PRIO_W-1:0] svc;
        logic [PRIO_W-1:0] debug;
        logic [PRIO_W-1:0] pendsv;
        logic [PRIO_W-1:0] tick;
    } sys_prio_t;

    // Synchronous system event strobes from the core
    typedef struct packed {
        logic hard_fault;
        logic mem_fault;
        logic bus_fault;
        logic usage_fault;
        logic supervisor_call;
        logic debug_monitor;
        logic pendable_service_request;
    } sys_event_t;

    // Vector handed to the core
    typedef struct packed {
        logic signed [7:0] num;
        logic [IDX_W-1:0] idx;
        logic [31:0] addr;
    } vector_t;

    // Result of a priority search
    typedef struct packed {
        logic found;
        logic [IDX_W-1:0] idx;
        logic [KEY_W-1:0] key;
    } pick_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HANDLER = 2'b01,
        ST_CHAIN = 2'b10
    } ctrl_state_t;
endpackage

//--- verilog/core_tick_timer.sv
// 24-bit reloading down counter raising one pulse per expiry
`timescale 1ns/10ps
module core_tick_timer #(
    parameter int WIDTH = irq_pkg::TICK_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic enable,
    input wire logic [WIDTH-1:0] reload,
    // Status
    output logic [WIDTH-1:0] count,
    output logic expire
);
    import irq_pkg::*;

    logic [WIDTH-1:0] next_count;
    logic hit;

    // Reaching one ends the interval; a zero reload never fires
    assign hit = enable && (count == WIDTH'(1));
    assign next_count = !enable ? reload :
                        (hit || count == '0) ? reload :
                        count - WIDTH'(1);

    // Counter and expiry strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            count <= '0;
            expire <= 1'b0;
        end else begin
            count <= next_count;
            expire <= hit && (reload != '0);
        end
    end
endmodule // core_tick_timer

//--- verilog/nested_vector_irq_unit.sv
// Nested vectored interrupt unit with system tick source
//
// Behaviour
// - 64 peripheral lines, 25 unwired and ignored, plus 16 system entries.
// - Every interrupt but NMI and hard fault has a programmable priority of eight levels; reset is fixed too.
// - Priority splits into group part for preemption and sub-priority.
// - Peripheral request counts only with peripheral and controller enables set.
// - Software may pend any wired peripheral line and request a whole-system reset.
// - Track nested handlers; chain straight to next pending one on exit.
// - Tick timer is 24-bit reloading down counter raising its own exception.
// - Vector table: one word per number, -16 at zero, four bytes apart.
// - Number -15 holds reset entry, -14 the non-maskable handler.
// - Faults take -13 to -10; -9 to -6 and -3 are reserved.
// - -5 supervisor call, -4 debug, -2 pendable request, -1 tick.
// - Peripheral n vectors at 0x40 plus 4n per the fixed source list.
`timescale 1ns/10ps
module nested_vector_irq_unit #(
    parameter int NUM_LINES = irq_pkg::NUM_PERIPH
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Peripheral requests and enables
    input wire logic [NUM_LINES-1:0] periph_irq,
    input wire logic [NUM_LINES-1:0] periph_src_en,
    input wire logic [NUM_LINES-1:0] irq_enable,
    input wire logic [NUM_LINES-1:0][irq_pkg::PRIO_W-1:0] irq_prio,
    // Software pend control, one-cycle strobes
    input wire logic [NUM_LINES-1:0] sw_set_pend,
    input wire logic [NUM_LINES-1:0] sw_clr_pend,
    input wire logic sw_sys_reset,
    // System exception configuration and events
    input wire logic [1:0] sub_prio_bits,
    input wire irq_pkg::sys_prio_t sys_prio,
    input wire irq_pkg::sys_event_t sys_event,
    input wire logic nmi_pin,
    // Tick timer control
    input wire logic tick_enable,
    input wire logic tick_irq_enable,
    input wire logic [irq_pkg::TICK_W-1:0] tick_reload,
    // Core handshake
    input wire logic exc_take,
    input wire logic exc_exit,
    output logic exc_req,
    output irq_pkg::vector_t exc_vector,
    output logic tail_chain,
    output logic [irq_pkg::KEY_W-1:0] run_level,
    output logic [irq_pkg::TICK_W-1:0] tick_count,
    output logic sys_reset_req
);
    import irq_pkg::*;

    // Lowest key wins; strict compare keeps the lower number on a tie
    function automatic pick_t pick(input logic [NUM_EXC-1:0] mask,
                                   input key_arr_t keys);
        pick_t p;
        p = '{found: 1'b0, idx: '0, key: KEY_IDLE};
        for (int i = 0; i < NUM_EXC; i++) begin
            if (mask[i] && (!p.found || keys[i] < p.key)) begin
                p.found = 1'b1;
                p.idx = IDX_W'(i);
                p.key = keys[i];
            end
        end
        return p;
    endfunction

    // Table address of an index, four bytes per exception number
    function automatic logic [31:0] vec_addr(input logic [IDX_W-1:0] idx);
        return VEC_BASE + {23'h0, idx, 2'b00};
    endfunction

    // Programmable priority of a system slot; fixed and reserved read zero
    function automatic logic [PRIO_W-1:0] sys_prio_of(
        input logic [IDX_W-1:0] idx,
        input sys_prio_t sp
    );
        case (idx)
            IDX_MEM: return sp.mem;
            IDX_BUS: return sp.bus;
            IDX_USAGE: return sp.usage;
            IDX_SVC: return sp.svc;
            IDX_DEBUG: return sp.debug;
            IDX_PENDSV: return sp.pendsv;
            IDX_TICK: return sp.tick;
            default: return '0;
        endcase
    endfunction

    // Strobe that pends a system slot; reset and reserved never pend
    function automatic logic sys_strobe_of(
        input logic [IDX_W-1:0] idx,
        input sys_event_t ev,
        input logic nmi_rise,
        input logic tick_rise
    );
        case (idx)
            IDX_NMI: return nmi_rise;
            IDX_HARD: return ev.hard_fault;
            IDX_MEM: return ev.mem_fault;
            IDX_BUS: return ev.bus_fault;
            IDX_USAGE: return ev.usage_fault;
            IDX_SVC: return ev.supervisor_call;
            IDX_DEBUG: return ev.debug_monitor;
            IDX_PENDSV: return ev.pendable_service_request;
            IDX_TICK: return tick_rise;
            default: return 1'b0;
        endcase
    endfunction

    // Pending and active bookkeeping
    logic [NUM_EXC-1:0] pend;
    logic [NUM_EXC-1:0] active;
    logic [NUM_EXC-1:0] next_pend;
    logic [NUM_EXC-1:0] next_active;

    // Masks of one bit per table entry
    logic [NUM_EXC-1:0] set_mask;
    logic [NUM_EXC-1:0] clr_mask;
    logic [NUM_EXC-1:0] allow_mask;
    logic [NUM_EXC-1:0] ready;
    logic [NUM_EXC-1:0] take_hot;
    logic [NUM_EXC-1:0] exit_hot;
    logic [NUM_EXC-1:0] remain;

    // Priorities and search keys
    logic [NUM_EXC-1:0][PRIO_W-1:0] prio_of;
    logic [NUM_EXC-1:0] fixed_of;
    key_arr_t full_key;
    key_arr_t group_key;
    logic [PRIO_W-1:0] group_mask;
    logic [NUM_SYS-1:0] sys_set;

    // Search results and running level
    pick_t winner;
    pick_t current;
    pick_t after_exit;
    logic [KEY_W-1:0] level_now;
    logic [KEY_W-1:0] level_eff;
    logic can_preempt;

    // Request, vector and sequencing
    logic next_req;
    vector_t next_vector;
    ctrl_state_t state;
    ctrl_state_t next_state;

    // Pin synchroniser and event strobes
    logic nmi_meta;
    logic nmi_sync;
    logic nmi_prev;
    logic nmi_edge;
    logic tick_expire;
    logic tick_pend;

    // Tick timer, its expiry pends the tick exception
    core_tick_timer #(
        .WIDTH(TICK_W)
    ) tick_timer (
        .mclk(mclk),
        .rst(rst),
        .enable(tick_enable),
        .reload(tick_reload),
        .count(tick_count),
        .expire(tick_expire)
    );

    // Non-maskable pin is asynchronous: two stages before edge detection
    always_ff @(posedge mclk) begin
        if (rst) begin
            nmi_meta <= 1'b0;
            nmi_sync <= 1'b0;
            nmi_prev <= 1'b0;
        end else begin
            nmi_meta <= nmi_pin;
            nmi_sync <= nmi_meta;
            nmi_prev <= nmi_sync;
        end
    end

    // Priority and pend strobe per system slot, decoded by slot index
    genvar s;
    generate
        for (s = 0; s < NUM_SYS; s++) begin : gen_sys
            assign prio_of[s] = sys_prio_of(IDX_W'(s), sys_prio);
            assign sys_set[s] = sys_strobe_of(IDX_W'(s), sys_event,
                nmi_edge, tick_pend);
        end
    endgenerate
    assign prio_of[NUM_EXC-1:NUM_SYS] = irq_prio;
    assign fixed_of = NUM_EXC'(16'h000F);

    // Group part masks away the low sub-priority bits
    assign group_mask = PRIO_W'(3'h7 << sub_prio_bits);

    // Keys: reset, NMI and hard fault sit above every programmable level
    genvar g;
    generate
        for (g = 0; g < NUM_EXC; g++) begin : gen_key
            logic [KEY_W-1:0] fkey;
            assign fkey = (g == IDX_RESET) ? KEY_RESET :
                          (g == IDX_NMI) ? KEY_NMI : KEY_HARD;
            assign full_key[g] = fixed_of[g] ? fkey :
                KEY_PROG_BASE + KEY_W'(prio_of[g]);
            assign group_key[g] = fixed_of[g] ? fkey :
                KEY_PROG_BASE + KEY_W'(prio_of[g] & group_mask);
        end
    endgenerate

    // Pin edge and tick expiry; a level pin would pend again after take
    assign nmi_edge = nmi_sync & ~nmi_prev;
    assign tick_pend = tick_expire & tick_irq_enable;

    // Line sets pending only while both enables are on; software pend too
    assign set_mask = {
        (periph_irq & periph_src_en & irq_enable) | sw_set_pend,
        sys_set
    } & {PERIPH_WIRED, SYS_PENDABLE};

    assign take_hot = exc_take ? (NUM_EXC'(1) << exc_vector.idx) : '0;
    assign exit_hot = (exc_exit && current.found) ?
                      (NUM_EXC'(1) << current.idx) : '0;
    assign clr_mask = take_hot | {sw_clr_pend, {NUM_SYS{1'b0}}};

    // Set wins over clear so a request in the clearing cycle survives
    assign next_pend = (pend & ~clr_mask) | set_mask;
    assign next_active = (active & ~exit_hot) | take_hot;

    // Only controller-enabled, wired lines compete for service
    assign allow_mask = {irq_enable & PERIPH_WIRED, SYS_PENDABLE};
    assign ready = pend & allow_mask;

    // Winner among pending, running handler, and level after its exit
    assign remain = active & ~exit_hot;
    assign winner = pick(ready, full_key);
    assign current = pick(active, group_key);
    assign after_exit = pick(remain, group_key);
    assign level_now = current.found ? current.key : KEY_IDLE;
    assign level_eff = exc_exit ? after_exit.key : level_now;

    // Only a strictly lower group key preempts the running level
    assign can_preempt = winner.found &&
                         (group_key[winner.idx] < level_eff);
    assign next_req = can_preempt && !exc_take;
    assign next_vector = '{
        num: 8'(signed'({1'b0, winner.idx}) - 8'sd16),
        idx: winner.idx,
        addr: vec_addr(winner.idx)
    };

    // Exit with a qualifying request skips the idle step
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (exc_take)
                    next_state = ST_HANDLER;
            end
            ST_HANDLER: begin
                if (exc_exit && !exc_take)
                    next_state = can_preempt ? ST_CHAIN :
                                 (after_exit.found ? ST_HANDLER : ST_IDLE);
            end
            ST_CHAIN: begin
                if (exc_take)
                    next_state = ST_HANDLER;
                else if (!can_preempt)
                    next_state = current.found ? ST_HANDLER : ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Pending and active bookkeeping
    always_ff @(posedge mclk) begin
        if (rst) begin
            pend <= '0;
            active <= '0;
            state <= ST_IDLE;
        end else begin
            pend <= next_pend;
            active <= next_active;
            state <= next_state;
        end
    end

    // Registered request and vector toward the core
    always_ff @(posedge mclk) begin
        if (rst) begin
            exc_req <= 1'b0;
            exc_vector <= '0;
            run_level <= KEY_IDLE;
            sys_reset_req <= 1'b0;
        end else begin
            exc_req <= next_req;
            exc_vector <= next_vector;
            run_level <= level_eff;
            sys_reset_req <= sw_sys_reset;
        end
    end

    // Flags that the pending request is served without unstacking
    assign tail_chain = (state == ST_CHAIN) && exc_req;
endmodule // nested_vector_irq_unit

//--- verification/irq_checker.sv
// Port-level assertions for the nested interrupt unit
`timescale 1ns/10ps
module irq_checker #(
    parameter int NUM_LINES = irq_pkg::NUM_PERIPH
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Watched inputs
    input wire logic [NUM_LINES-1:0] irq_enable,
    input wire logic sw_sys_reset,
    input wire logic tick_enable,
    input wire logic [irq_pkg::TICK_W-1:0] tick_reload,
    input wire logic exc_take,
    input wire logic exc_exit,
    // Watched outputs
    input wire logic exc_req,
    input wire irq_pkg::vector_t exc_vector,
    input wire logic tail_chain,
    input wire logic [irq_pkg::TICK_W-1:0] tick_count,
    input wire logic sys_reset_req
);
    import irq_pkg::*;
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_reset_req_delay: assert property (
        sw_sys_reset |=> sys_reset_req)
        else $error("reset request late");
    a_vector_addr: assert property (
        exc_req |-> exc_vector.addr == {23'h0, exc_vector.idx, 2'b00})
        else $error("vector address off");
    a_index_number: assert property (
        exc_req |-> {1'b0, exc_vector.idx} == exc_vector.num + 8'sh10)
        else $error("index and number disagree");
    a_no_reserved: assert property (
        exc_req |-> !(exc_vector.num inside {-16, -15, [-9:-6], -3, 4,
        [9:12], 15, 30, 31, 34, 35, 42, [50:63]}))
        else $error("reserved slot requested");
    a_take_drops: assert property (
        exc_take |=> !exc_req)
        else $error("request held after take");
    a_chain_after_exit: assert property (
        $rose(tail_chain) |-> $past(exc_exit))
        else $error("chain without exit");
    // Past enable is the one the unit judged when it raised the request
    a_enable_gates: assert property (
        exc_req && exc_vector.num >= 0 |->
        ($past(irq_enable) >> exc_vector.num[5:0]) & 1)
        else $error("disabled line served");
    a_tick_down: assert property (
        tick_enable && $past(tick_enable) && $past(tick_count) > 24'h1
        |-> tick_count == $past(tick_count) - 24'h1)
        else $error("tick not counting down");
    a_tick_reload: assert property (
        tick_enable && $past(tick_enable) && $past(tick_count) == 24'h1
        |-> tick_count == $past(tick_reload))
        else $error("tick not reloaded");
endmodule // irq_checker

//--- verification/core_model.sv
// Behavioural core that takes vectors and leaves handlers
`timescale 1ns/10ps
module core_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Controller handshake
    input wire logic exc_req,
    input wire irq_pkg::vector_t exc_vector,
    output logic exc_take,
    output logic exc_exit,
    // Bench control and log
    input wire logic take_en,
    input wire logic exit_en,
    output int taken_cnt,
    output logic signed [7:0] taken_num
);
    import irq_pkg::*;
    int depth;
    int idle;
    // Strobes change off the falling edge; take only on a standing request
    always @(negedge mclk) begin
        exc_take <= 1'b0;
        exc_exit <= 1'b0;
        idle <= idle + 1;
        if (rst) begin
            depth <= 0;
            idle <= 0;
            taken_cnt <= 0;
            taken_num <= 8'sh00;
        end else if (take_en && exc_req) begin
            exc_take <= 1'b1;
            taken_num <= exc_vector.num;
            taken_cnt <= taken_cnt + 1;
            depth <= depth + 1;
            idle <= 0;
        end else if (exit_en && depth > 0 && idle > 2) begin
            // One exit per taken handler, innermost first
            exc_exit <= 1'b1;
            depth <= depth - 1;
            idle <= 0;
        end
    end
endmodule // core_model

//--- verification/tb.sv
// Self-checking bench for the nested interrupt unit
`timescale 1ns/10ps
module tb;
    import irq_pkg::*;
    logic mclk, rst, sw_sys_reset, nmi_pin, tick_enable, tick_irq_enable;
    logic [63:0] periph_irq, periph_src_en, irq_enable, sw_set_pend;
    logic [63:0] sw_clr_pend;
    logic [63:0][2:0] irq_prio;
    logic [1:0] sub_prio_bits;
    sys_prio_t sys_prio;
    sys_event_t sys_event;
    logic [23:0] tick_reload, tick_count;
    logic exc_take, exc_exit, exc_req, tail_chain, sys_reset_req;
    logic take_en, exit_en;
    vector_t exc_vector;
    logic [3:0] run_level;
    logic signed [7:0] taken_num;
    int taken_cnt, mismatches, cmp_count, k;
    int sys_nums[7] = '{-13, -12, -11, -10, -5, -4, -2};

    // Unit under test and the core at its far side
    nested_vector_irq_unit dut_u (.mclk, .rst, .periph_irq, .periph_src_en,
        .irq_enable, .irq_prio, .sw_set_pend, .sw_clr_pend,
        .sw_sys_reset, .sub_prio_bits, .sys_prio, .sys_event, .nmi_pin,
        .tick_enable, .tick_irq_enable, .tick_reload, .exc_take, .exc_exit,
        .exc_req, .exc_vector, .tail_chain, .run_level, .tick_count,
        .sys_reset_req);
    core_model core_u (.mclk, .rst, .exc_req, .exc_vector, .exc_take,
        .exc_exit, .take_en, .exit_en, .taken_cnt, .taken_num);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("mismatches %0d compares %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Wait for a vector, judge it, drop its line, let the core take it
    task automatic serve(input int n, input logic chain);
        int i;
        int c;
        for (i = 0; i < 100 && exc_req !== 1'b1; i++) @(negedge mclk);
        check({31'h0, exc_req}, 32'h1);
        check({24'h0, exc_vector.num}, {24'h0, n[7:0]});
        check(exc_vector.addr, 32'h40 + 32'(4 * n));
        check({31'h0, tail_chain}, {31'h0, chain});
        if (n >= 0) periph_irq[n] = 1'b0;
        c = taken_cnt;
        take_en = 1'b1;
        for (i = 0; i < 20 && taken_cnt == c; i++) @(negedge mclk);
        @(negedge mclk);
        take_en = 1'b0;
        check({24'h0, taken_num}, {24'h0, n[7:0]});
        repeat (8) @(negedge mclk);
    endtask

    // Plain line: vector and running level
    task automatic t_walk;
        irq_prio[5] = 3'h2;
        periph_irq[5] = 1'b1;
        serve(5, 1'b0);
        check({28'h0, run_level}, 32'h5);
        exit_en = 1'b1;
    endtask

    // Either enable off, or an unwired line, gives nothing
    task automatic t_gate;
        for (k = 0; k < 3; k++) begin
            periph_src_en[6] = (k != 0);
            irq_enable[6] = (k != 1);
            periph_irq[k < 2 ? 6 : 4] = 1'b1;
            repeat (6) @(negedge mclk);
            check({31'h0, exc_req}, 32'h0);
            periph_irq = '0;
        end
        irq_enable = '1;
        periph_src_en = '1;
    endtask

    // Lower value first, then lower number on ties; the loser chains
    task automatic t_order;
        irq_prio[6] = 3'h3;
        irq_prio[7] = 3'h1;
        irq_prio[13] = 3'h2;
        irq_prio[14] = 3'h2;
        periph_irq[7:6] = 2'h3;
        serve(7, 1'b0);
        serve(6, 1'b1);
        periph_irq[14:13] = 2'h3;
        serve(13, 1'b0);
        serve(14, 1'b1);
    endtask

    // Same group waits, better group preempts, then exit chains
    task automatic t_nest;
        sub_prio_bits = 2'h1;
        exit_en = 1'b0;
        irq_prio[18:16] = {3'h2, 3'h5, 3'h4};
        periph_irq[16] = 1'b1;
        serve(16, 1'b0);
        periph_irq[17] = 1'b1;
        repeat (6) @(negedge mclk);
        check({31'h0, exc_req}, 32'h0);
        periph_irq[18] = 1'b1;
        serve(18, 1'b0);
        exit_en = 1'b1;
        serve(17, 1'b1);
        sub_prio_bits = 2'h0;
    endtask

    // System events, NMI, tick, software pend and reset
    task automatic t_system;
        for (k = 0; k < 7; k++) begin
            sys_event = sys_event_t'(7'h40 >> k);
            @(negedge mclk);
            sys_event = '0;
            serve(sys_nums[k], 1'b0);
        end
        nmi_pin = 1'b1;
        serve(-14, 1'b0);
        nmi_pin = 1'b0;
        tick_irq_enable = 1'b1;
        tick_enable = 1'b1;
        serve(-1, 1'b0);
        tick_enable = 1'b0;
        tick_irq_enable = 1'b0;
        // Pend behind a cleared enable, clear it, then re-enable: silence
        irq_enable[46] = 1'b0;
        sw_set_pend[46] = 1'b1;
        @(negedge mclk);
        sw_set_pend = '0;
        sw_clr_pend[46] = 1'b1;
        @(negedge mclk);
        sw_clr_pend = '0;
        irq_enable[46] = 1'b1;
        repeat (4) @(negedge mclk);
        check({31'h0, exc_req}, 32'h0);
        check({8'h0, tick_count}, {8'h0, tick_reload});
        periph_irq[46] = 1'b1;
        serve(46, 1'b0);
        sw_set_pend[8] = 1'b1;
        @(negedge mclk);
        sw_set_pend = '0;
        serve(8, 1'b0);
        sw_sys_reset = 1'b1;
        @(negedge mclk);
        sw_sys_reset = 1'b0;
        check({31'h0, sys_reset_req}, 32'h1);
        @(negedge mclk);
        check({31'h0, sys_reset_req}, 32'h0);
    endtask

    // Free-running clock, 4 ns period
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Cut a hang short well past the expected run length
    initial begin
        #40000;
        mismatches++;
        final_report();
    end

    // Main sequence
    initial begin
        {mismatches, cmp_count} = '0;
        {periph_irq, sw_set_pend, irq_prio, sys_event, sys_prio} = '0;
        {sw_sys_reset, nmi_pin, tick_enable, tick_irq_enable} = '0;
        {take_en, exit_en, sub_prio_bits} = '0;
        sw_clr_pend = '0;
        periph_src_en = '1;
        irq_enable = '1;
        tick_reload = 24'h40;
        rst = 1'b1;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        t_walk();
        t_gate();
        t_order();
        t_nest();
        t_system();
        final_report();
    end
endmodule // tb

bind nested_vector_irq_unit irq_checker #(.NUM_LINES(NUM_LINES)) chk_u (
    .mclk, .rst, .irq_enable, .sw_sys_reset, .tick_enable, .tick_reload,
    .exc_take, .exc_exit, .exc_req, .exc_vector, .tail_chain, .tick_count,
    .sys_reset_req);
